// ### rtl/bst_defines.svh
// Constants of the boundary-scan test access port
`ifndef BST_DEFINES_SVH
`define BST_DEFINES_SVH
// ----------------------------------------------------------------
// Register lengths
// ----------------------------------------------------------------
`define BST_IR_LEN    10
`define BST_ID_LEN    32
`define BST_BSR_DFLT  288
// ----------------------------------------------------------------
// Instruction codes and capture pattern
// ----------------------------------------------------------------
`define BST_OP_EXTEST 10'h000
`define BST_OP_SAMPLE 10'h055
`define BST_OP_IDCODE 10'h059
`define BST_OP_BYPASS 10'h3ff
`define BST_IR_CAP    10'h001
// ----------------------------------------------------------------
// Identification word field positions
// ----------------------------------------------------------------
`define BST_ID_VER_LSB  28
`define BST_ID_PART_LSB 12
`define BST_ID_MFR_LSB  1
`endif

// ### rtl/bst_pkg.sv
// Types shared by the boundary-scan test access port
package bst_pkg;
  // Test controller states
  typedef enum logic [3:0] {
    TLR   = 4'b0000,
    RTI   = 4'b0001,
    SELDR = 4'b0010,
    CAPDR = 4'b0011,
    SHDR  = 4'b0100,
    EX1DR = 4'b0101,
    PSDR  = 4'b0110,
    EX2DR = 4'b0111,
    UPDR  = 4'b1000,
    SELIR = 4'b1001,
    CAPIR = 4'b1010,
    SHIR  = 4'b1011,
    EX1IR = 4'b1100,
    PSIR  = 4'b1101,
    EX2IR = 4'b1110,
    UPIR  = 4'b1111
  } bst_tap_e;
  // Test port input pins
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bst_pins_s;
endpackage

// ### rtl/bst_tap.sv
// Boundary-scan test access port with boundary cells and id word
`timescale 1ns/1ps
`include "bst_defines.svh"

// Functional notes
// - Test access and boundary scan behave as the 1990 test port standard.
// - Instruction register is ten bits; controller shifts ten per load.
// - Bypass instruction puts a one-bit register between data in and out.
// - Core logic keeps running in bypass; scan data passes through.
// - Identification instruction puts a 32-bit word on the scan path.
// - Id word: 4-bit version, 16-bit part, 11-bit maker, one bit.
// - Lowest bit of the id word is always one.
// - Id fields are written most significant bit leftmost.
// - Sample/preload captures pins without disturbing, and preloads outputs.
// - External test drives cell values out and captures input pins.
// - Boundary length is a variant parameter: 288, 312, 360 or 480.
// - Length one means no cells; external test and sample pick bypass.
// - With the test port unused, its four pins serve as user pins.
// - Programming instructions are accepted through the same port.
module bst_tap #(
  parameter int          BSR_LEN  = `BST_BSR_DFLT,
  // Identity values below are arbitrary
  parameter logic [3:0]  ID_VER   = 4'h1,
  parameter logic [15:0] ID_PART  = 16'h1234,
  parameter logic [10:0] ID_MFR   = 11'h2a5,
  parameter int          BW       = (BSR_LEN > 1) ? BSR_LEN : 1
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire bst_pkg::bst_pins_s pins,
  input  wire logic             port_en,
  input  wire logic [BW-1:0]    pin_in,
  input  wire logic [BW-1:0]    core_out,
  input  wire logic             user_out,
  input  wire logic             user_oe_n,
  output logic                  tdo_out,
  output logic                  tdo_oe_n,
  output logic [BW-1:0]         pin_out,
  output logic [BW-1:0]         core_in,
  output logic [2:0]            user_in,
  output logic [9:0]            ir_value,
  output logic                  prog_active,
  output logic                  extest_active,
  output bst_pkg::bst_tap_e     tap_state
);
  localparam bit HAS_BSR = (BSR_LEN > 1);
  localparam logic [31:0] ID_WORD = {ID_VER, ID_PART, ID_MFR, 1'b1};

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              tck_s1;
    logic              tck_s2;
    logic              tck_s3;
    logic              tms_s1;
    logic              tms_s2;
    logic              tdi_s1;
    logic              tdi_s2;
    logic              en_s1;
    logic              en_s2;
    logic [BW-1:0]     pin_s1;
    logic [BW-1:0]     pin_s2;
    bst_pkg::bst_tap_e state;
    logic [9:0]        ir_sh;
    logic [9:0]        ir;
    logic              byp;
    logic [31:0]       id_sh;
    logic [BW-1:0]     bsr_sh;
    logic [BW-1:0]     bsr_upd;
    logic [BW-1:0]     pin_out;
    logic              tdo;
    logic              tdo_oe_n;
  } bst_state_s;

  bst_state_s s_ff;
  bst_state_s nxt_s;
  logic       rise;
  logic       fall;
  logic       active;
  logic       sel_id;
  logic       sel_bsr;
  logic       sel_byp;
  logic       extest;

  // ----------------------------------------------------------------
  // Controller next state
  // ----------------------------------------------------------------
  // standard sixteen-state walk
  function automatic bst_pkg::bst_tap_e tap_next(
    input bst_pkg::bst_tap_e st,
    input logic              tms
  );
    unique case (st)
      bst_pkg::TLR:   tap_next = tms ? bst_pkg::TLR   : bst_pkg::RTI;
      bst_pkg::RTI:   tap_next = tms ? bst_pkg::SELDR : bst_pkg::RTI;
      bst_pkg::SELDR: tap_next = tms ? bst_pkg::SELIR : bst_pkg::CAPDR;
      bst_pkg::CAPDR: tap_next = tms ? bst_pkg::EX1DR : bst_pkg::SHDR;
      bst_pkg::SHDR:  tap_next = tms ? bst_pkg::EX1DR : bst_pkg::SHDR;
      bst_pkg::EX1DR: tap_next = tms ? bst_pkg::UPDR  : bst_pkg::PSDR;
      bst_pkg::PSDR:  tap_next = tms ? bst_pkg::EX2DR : bst_pkg::PSDR;
      bst_pkg::EX2DR: tap_next = tms ? bst_pkg::UPDR  : bst_pkg::SHDR;
      bst_pkg::UPDR:  tap_next = tms ? bst_pkg::SELDR : bst_pkg::RTI;
      bst_pkg::SELIR: tap_next = tms ? bst_pkg::TLR   : bst_pkg::CAPIR;
      bst_pkg::CAPIR: tap_next = tms ? bst_pkg::EX1IR : bst_pkg::SHIR;
      bst_pkg::SHIR:  tap_next = tms ? bst_pkg::EX1IR : bst_pkg::SHIR;
      bst_pkg::EX1IR: tap_next = tms ? bst_pkg::UPIR  : bst_pkg::PSIR;
      bst_pkg::PSIR:  tap_next = tms ? bst_pkg::EX2IR : bst_pkg::PSIR;
      bst_pkg::EX2IR: tap_next = tms ? bst_pkg::UPIR  : bst_pkg::SHIR;
      bst_pkg::UPIR:  tap_next = tms ? bst_pkg::SELDR : bst_pkg::RTI;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Clock edges found from the second and third sync stages
  assign rise   = s_ff.tck_s2 & ~s_ff.tck_s3;
  assign fall   = ~s_ff.tck_s2 & s_ff.tck_s3;
  assign active = s_ff.en_s2;
  assign sel_id = (s_ff.ir == `BST_OP_IDCODE);
  // no cells means these fall back to bypass
  assign sel_bsr = HAS_BSR && ((s_ff.ir == `BST_OP_EXTEST) ||
                               (s_ff.ir == `BST_OP_SAMPLE));
  // bypass for its own code and every code without a register
  assign sel_byp = !sel_id && !sel_bsr;
  assign extest  = HAS_BSR && (s_ff.ir == `BST_OP_EXTEST);

  // ----------------------------------------------------------------
  // Next state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    // Two-stage synchronisers for all pins, three stages on the test clock
    nxt_s.tck_s1 = pins.tck;
    nxt_s.tck_s2 = s_ff.tck_s1;
    nxt_s.tck_s3 = s_ff.tck_s2;
    nxt_s.tms_s1 = pins.tms;
    nxt_s.tms_s2 = s_ff.tms_s1;
    nxt_s.tdi_s1 = pins.tdi;
    nxt_s.tdi_s2 = s_ff.tdi_s1;
    nxt_s.en_s1  = port_en;
    nxt_s.en_s2  = s_ff.en_s1;
    nxt_s.pin_s1 = pin_in;
    nxt_s.pin_s2 = s_ff.pin_s1;
    // core drives pins unless external test is loaded
    // external test drives the update cells out
    nxt_s.pin_out = extest ? s_ff.bsr_upd : core_out;
    if (active && rise) begin
      nxt_s.state = tap_next(s_ff.state, s_ff.tms_s2);
      unique case (s_ff.state)
        bst_pkg::TLR: begin
          nxt_s.ir = `BST_OP_IDCODE;
        end
        bst_pkg::CAPDR: begin
          nxt_s.byp = 1'b0;
          if (sel_id) begin
            nxt_s.id_sh = ID_WORD;
          end
          if (sel_bsr) begin
            nxt_s.bsr_sh = s_ff.pin_s2;
          end
        end
        bst_pkg::SHDR: begin
          // lowest bit first toward data out
          if (sel_id) begin
            nxt_s.id_sh = {s_ff.tdi_s2, s_ff.id_sh[31:1]};
          end else if (sel_bsr) begin
            // Shift through a wider copy so one cell needs no special case
            nxt_s.bsr_sh = BW'({s_ff.tdi_s2, s_ff.bsr_sh} >> 1);
          end else begin
            nxt_s.byp = s_ff.tdi_s2;
          end
        end
        bst_pkg::UPDR: begin
          if (sel_bsr) begin
            nxt_s.bsr_upd = s_ff.bsr_sh;
          end
        end
        bst_pkg::CAPIR: begin
          nxt_s.ir_sh = `BST_IR_CAP;
        end
        bst_pkg::SHIR: begin
          nxt_s.ir_sh = {s_ff.tdi_s2, s_ff.ir_sh[9:1]};
        end
        bst_pkg::UPIR: begin
          // any code is accepted, programming ones included
          nxt_s.ir = s_ff.ir_sh;
        end
        default: begin
        end
      endcase
    end
    if (active && fall) begin
      // data out driven only in shift states
      nxt_s.tdo_oe_n = 1'b1;
      if (s_ff.state == bst_pkg::SHIR) begin
        nxt_s.tdo      = s_ff.ir_sh[0];
        nxt_s.tdo_oe_n = 1'b0;
      end else if (s_ff.state == bst_pkg::SHDR) begin
        nxt_s.tdo_oe_n = 1'b0;
        if (sel_id) begin
          nxt_s.tdo = s_ff.id_sh[0];
        end else if (sel_bsr) begin
          nxt_s.tdo = s_ff.bsr_sh[0];
        end else begin
          nxt_s.tdo = s_ff.byp;
        end
      end
    end
    // unused port hands the data out pin to the user
    if (!active) begin
      nxt_s.state    = bst_pkg::TLR;
      nxt_s.ir       = `BST_OP_IDCODE;
      nxt_s.tdo      = user_out;
      nxt_s.tdo_oe_n = user_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_ff          <= '0;
      s_ff.state    <= bst_pkg::TLR;
      s_ff.ir       <= `BST_OP_IDCODE;
      s_ff.tdo_oe_n <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign tdo_out       = s_ff.tdo;
  assign tdo_oe_n      = s_ff.tdo_oe_n;
  assign pin_out       = s_ff.pin_out;
  assign core_in       = s_ff.pin_s2;
  assign user_in       = {s_ff.tck_s2, s_ff.tms_s2, s_ff.tdi_s2};
  assign ir_value      = s_ff.ir;
  assign tap_state     = s_ff.state;
  assign extest_active = extest;
  assign prog_active   = (s_ff.ir != `BST_OP_EXTEST) &&
                         (s_ff.ir != `BST_OP_SAMPLE) &&
                         (s_ff.ir != `BST_OP_IDCODE) &&
                         (s_ff.ir != `BST_OP_BYPASS);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence step_in(bst_pkg::bst_tap_e st);
    active && rise && (s_ff.state == st);
  endsequence

  sequence ir_loaded;
    step_in(bst_pkg::CAPIR) ##1 (s_ff.ir_sh == `BST_IR_CAP);
  endsequence

  AST_TLR_HOLD: assert property (
    step_in(bst_pkg::TLR) and s_ff.tms_s2 |=> s_ff.state == bst_pkg::TLR)
    else $error("reset state not held with mode high");
  AST_IR_CAPTURE: assert property (
    step_in(bst_pkg::CAPIR) |-> ir_loaded)
    else $error("instruction capture pattern wrong");
  AST_IR_UPDATE: assert property (
    step_in(bst_pkg::UPIR) |=> s_ff.ir == $past(s_ff.ir_sh))
    else $error("instruction not updated");
  AST_BYP_PATH: assert property (
    step_in(bst_pkg::SHDR) and sel_byp |=> s_ff.byp == $past(s_ff.tdi_s2))
    else $error("bypass bit not shifted");
  AST_ID_CAPTURE: assert property (
    step_in(bst_pkg::CAPDR) and sel_id |=> s_ff.id_sh == ID_WORD)
    else $error("id word not captured");
  AST_ID_LSB: assert property (
    active && fall && s_ff.state == bst_pkg::SHDR && sel_id &&
    s_ff.id_sh == ID_WORD |=> s_ff.tdo == 1'b1)
    else $error("id word lowest bit not one");
  AST_TDO_FLOAT: assert property (
    active && fall && s_ff.state != bst_pkg::SHDR &&
    s_ff.state != bst_pkg::SHIR |=> s_ff.tdo_oe_n)
    else $error("data out driven outside shift");
  AST_IR_SHIFT: assert property (
    step_in(bst_pkg::SHIR) |=> s_ff.ir_sh[9] == $past(s_ff.tdi_s2))
    else $error("instruction shift wrong");
  AST_EXTEST_DRIVE: assert property (
    extest |=> s_ff.pin_out == $past(s_ff.bsr_upd))
    else $error("cells not driving pins");
  AST_CORE_PASS: assert property (
    !extest |=> s_ff.pin_out == $past(core_out))
    else $error("core outputs disturbed");
  AST_NO_CELLS: assert property (
    step_in(bst_pkg::SHDR) and (!HAS_BSR && (s_ff.ir == `BST_OP_EXTEST ||
    s_ff.ir == `BST_OP_SAMPLE)) |=> s_ff.byp == $past(s_ff.tdi_s2))
    else $error("boundary codes not routed to bypass");
  AST_USER_PIN: assert property (
    !active |=> s_ff.tdo == $past(user_out))
    else $error("user pin not passed");
endmodule

// ### test/bst_jtag_model.sv
// Scan controller model driving the test port pins
`timescale 1ns/1ps
module bst_jtag_model (
  input  wire logic          mclk,
  output bst_pkg::bst_pins_s pins,
  input  wire logic          tdo_out,
  input  wire logic          tdo_oe_n
);
  // Test clock stands low between frames
  initial begin
    pins = '0;
  end
  // Force pin levels while the port serves as user pins
  task automatic hold(input bst_pkg::bst_pins_s v);
    pins = v;
  endtask
  // One test clock: 40 ns low, rise, 40 ns high, sample, fall
  task automatic step(input logic m, input logic di, output logic q);
    pins.tms = m;
    pins.tdi = di;
    repeat (4) @(negedge mclk);
    pins.tck = 1'b1;
    repeat (4) @(negedge mclk);
    // A floating data out reads as the inverse of its last level
    q = tdo_oe_n ? ~tdo_out : tdo_out;
    pins.tck = 1'b0;
  endtask
  // Full scan frame from idle back to idle
  task automatic scan(input logic ir, input int n,
                      input logic [511:0] din, output logic [511:0] dout);
    logic q;
    dout = '0;
    step(1'b1, pins.tdi, q);
    if (ir) step(1'b1, pins.tdi, q);
    step(1'b0, pins.tdi, q);
    step(1'b0, pins.tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, pins.tdi, q);
    step(1'b0, pins.tdi, q);
    @(negedge mclk);
    pins.tdi = ~pins.tdi;
    @(negedge mclk);
  endtask
endmodule

// ### test/boundary_scan_tap_tb.sv
// Self-checking bench of the boundary-scan test access port
`timescale 1ns/1ps
`include "bst_defines.svh"
module boundary_scan_tap_tb;
  // ----------------------------------------------------------------
  // Settings and signals
  // ----------------------------------------------------------------
  localparam int          L    = 288;
  // Identity values are arbitrary
  localparam logic [3:0]  VER  = 4'h6;
  localparam logic [15:0] PART = 16'hc3d1;
  localparam logic [10:0] MFR  = 11'h1b3;
  localparam logic [L-1:0] CORE = {9{32'h0ff05aa5}};
  localparam logic [L-1:0] P1   = {9{32'h13579bdf}};
  localparam logic [L-1:0] P2   = {9{32'h2468ace0}};
  localparam logic [L-1:0] Q    = {9{32'hc3a50f96}};
  logic               mclk;
  logic               reset_n;
  logic               port_en;
  logic               user_out;
  logic               user_oe_n;
  logic [L-1:0]       pin_in;
  logic [L-1:0]       pin_out;
  logic [L-1:0]       core_out;
  logic [L-1:0]       core_in;
  bst_pkg::bst_pins_s pins;
  bst_pkg::bst_pins_s pins_s1;
  logic               tdo_out;
  logic               tdo_oe_n;
  logic               tdo_s1;
  logic               tdo_oe_s1;
  logic               ext_s1;
  logic [2:0]         user_in;
  logic [9:0]         ir_value;
  logic               prog_active;
  logic               extest_active;
  bst_pkg::bst_tap_e  tap_state;
  logic [511:0]       d;
  int                 error_cnt;
  int                 check_count;
  // ----------------------------------------------------------------
  // Design, small variant and scan controllers
  // ----------------------------------------------------------------
  bst_tap #(.BSR_LEN(L), .ID_VER(VER), .ID_PART(PART), .ID_MFR(MFR))
    u_bst_tap (.mclk(mclk), .reset_n(reset_n), .pins(pins),
    .port_en(port_en), .pin_in(pin_in), .core_out(core_out),
    .user_out(user_out), .user_oe_n(user_oe_n), .tdo_out(tdo_out),
    .tdo_oe_n(tdo_oe_n), .pin_out(pin_out), .core_in(core_in),
    .user_in(user_in), .ir_value(ir_value), .prog_active(prog_active),
    .extest_active(extest_active), .tap_state(tap_state));
  bst_tap #(.BSR_LEN(1)) u_bst_tap_s1 (.mclk(mclk), .reset_n(reset_n),
    .pins(pins_s1), .port_en(port_en), .pin_in(pin_in[0]),
    .core_out(core_out[0]), .user_out(user_out), .user_oe_n(user_oe_n),
    .tdo_out(tdo_s1), .tdo_oe_n(tdo_oe_s1), .pin_out(), .core_in(),
    .user_in(), .ir_value(), .prog_active(), .extest_active(ext_s1),
    .tap_state());
  bst_jtag_model u_bst_jtag_model (.mclk(mclk), .pins(pins),
    .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n));
  bst_jtag_model u_bst_jtag_model_s1 (.mclk(mclk), .pins(pins_s1),
    .tdo_out(tdo_s1), .tdo_oe_n(tdo_oe_s1));
  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    close_out();
  end
  // ----------------------------------------------------------------
  // Compare and closing
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [511:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // reset state
  task automatic t_reset();
    repeat (16) @(negedge mclk);
    chk("tap_state", bst_pkg::TLR, tap_state);
    chk("ir_value", `BST_OP_IDCODE, ir_value);
    chk("tdo_oe_n", 1'b1, tdo_oe_n);
    chk("pin_out", '0, pin_out);
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
    u_bst_jtag_model.step(1'b0, 1'b0, d[0]);
    u_bst_jtag_model_s1.step(1'b0, 1'b0, d[0]);
    chk("tap_state", bst_pkg::RTI, tap_state);
  endtask
  task automatic t_idcode();
    u_bst_jtag_model.scan(1'b0, 32, '0, d);
    chk("id word", {VER, PART, MFR, 1'b1}, d[31:0]);
    chk("id lsb", 1'b1, d[0]);
    chk("tdo_oe_n", 1'b1, tdo_oe_n);
  endtask
  task automatic t_bypass();
    u_bst_jtag_model.scan(1'b1, 10, `BST_OP_BYPASS, d);
    chk("ir capture", `BST_IR_CAP, d[9:0]);
    chk("ir_value", `BST_OP_BYPASS, ir_value);
    // Core outputs change just before scan data passes through
    core_out = P2;
    u_bst_jtag_model.scan(1'b0, 8, 8'hb5, d);
    chk("bypass data", 8'h6a, d[7:0]);
    chk("pin_out", P2, pin_out);
    core_out = CORE;
  endtask
  task automatic t_codes();
    logic [9:0] op [5] = '{`BST_OP_EXTEST, `BST_OP_SAMPLE,
      `BST_OP_IDCODE, `BST_OP_BYPASS, 10'h2aa};
    for (int i = 0; i < 5; i++) begin
      u_bst_jtag_model.scan(1'b1, 10, op[i], d);
      chk("ir_value", op[i], ir_value);
      chk("prog_active", i == 4, prog_active);
      chk("extest_active", i == 0, extest_active);
    end
  endtask
  task automatic t_bsr();
    u_bst_jtag_model.scan(1'b1, 10, `BST_OP_SAMPLE, d);
    u_bst_jtag_model.scan(1'b0, L, Q, d);
    chk("bsr capture", P1, d[L-1:0]);
    chk("pin_out", CORE, pin_out);
    chk("core_in", P1, core_in);
    u_bst_jtag_model.scan(1'b1, 10, `BST_OP_EXTEST, d);
    chk("pin_out", Q, pin_out);
    @(negedge mclk);
    pin_in = P2;
    u_bst_jtag_model.scan(1'b0, L, '0, d);
    chk("bsr capture", P2, d[L-1:0]);
    chk("pin_out", '0, pin_out);
    chk("core_in", P2, core_in);
  endtask
  task automatic t_small();
    for (int i = 0; i < 2; i++) begin
      u_bst_jtag_model_s1.scan(1'b1, 10,
        i ? `BST_OP_SAMPLE : `BST_OP_EXTEST, d);
      chk("extest_active", 1'b0, ext_s1);
      u_bst_jtag_model_s1.scan(1'b0, 4, 4'h9, d);
      chk("bypass data", 4'h2, d[3:0]);
    end
  endtask
  task automatic t_tlr();
    u_bst_jtag_model.scan(1'b1, 10, `BST_OP_BYPASS, d);
    repeat (5) u_bst_jtag_model.step(1'b1, 1'b0, d[0]);
    chk("tap_state", bst_pkg::TLR, tap_state);
    chk("ir_value", `BST_OP_IDCODE, ir_value);
    u_bst_jtag_model.step(1'b0, 1'b0, d[0]);
    chk("tap_state", bst_pkg::RTI, tap_state);
  endtask
  task automatic t_user();
    @(negedge mclk);
    port_en = 1'b0;
    user_out = 1'b1;
    user_oe_n = 1'b0;
    u_bst_jtag_model.hold(3'b101);
    repeat (8) @(negedge mclk);
    chk("user_in", 3'b101, user_in);
    chk("tdo_out", 1'b1, tdo_out);
    chk("tdo_oe_n", 1'b0, tdo_oe_n);
    user_out = 1'b0;
    repeat (8) @(negedge mclk);
    chk("tdo_out", 1'b0, tdo_out);
    chk("tap_state", bst_pkg::TLR, tap_state);
  endtask
  // Main sequence
  initial begin
    reset_n = 1'b0;
    port_en = 1'b1;
    user_out = 1'b0;
    user_oe_n = 1'b1;
    pin_in = P1;
    core_out = CORE;
    error_cnt = 0;
    check_count = 0;
    t_reset();
    t_idcode();
    t_bypass();
    t_codes();
    t_bsr();
    t_small();
    t_tlr();
    t_user();
    close_out();
  end
endmodule
